// *** shared/charger_cfg_regs.vh ***
`ifndef CHARGER_CFG_REGS_VH
`define CHARGER_CFG_REGS_VH
// register offsets
`define OFS_SOLAR_TRACKING_CONTROL   8'h15
`define OFS_TEMPERATURE_CONTROL      8'h16
`define OFS_THERMISTOR_CHARGE_ADJUST 8'h17
// reset values
`define RST_SOLAR_TRACKING_CONTROL   8'hAA
`define RST_TEMPERATURE_CONTROL      8'hC0
`define RST_THERMISTOR_CHARGE_ADJUST 8'h7A
// writable bit masks (reserved bits zero)
`define MASK_SOLAR_TRACKING_CONTROL   8'hFF
`define MASK_TEMPERATURE_CONTROL      8'hFE
`define MASK_THERMISTOR_CHARGE_ADJUST 8'hFE
// bits restored on watchdog expiry
`define WDOG_TEMPERATURE_CONTROL      8'hF0
`define WDOG_THERMISTOR_CHARGE_ADJUST 8'hFE
// field positions
`define FLD_FRACTION_HI   7
`define FLD_FRACTION_LO   5
`define FLD_SETTLE_HI     4
`define FLD_SETTLE_LO     3
`define FLD_INTERVAL_HI   2
`define FLD_INTERVAL_LO   1
`define FLD_TRACK_EN      0
// timing in milliseconds
`define SETTLE_MS_0       50
`define SETTLE_MS_1       300
`define SETTLE_MS_2       2000
`define SETTLE_MS_3       5000
`define INTERVAL_MS_0     30000
`define INTERVAL_MS_1     120000
`define INTERVAL_MS_2     600000
`define INTERVAL_MS_3     1800000
// clock rate
`define CLK_HZ            40000000
`define CYCLES_PER_MS     (`CLK_HZ / 1000)
`endif

// *** rtl/ms_tick_counter.v ***
`timescale 1ns/1ps
// counts milliseconds: reloadable down counter with a per-ms prescaler
module ms_tick_counter #(
    parameter CYCLES_PER_MS = 40000
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    // control
    input  wire        load,
    input  wire [31:0] load_ms,
    // status
    output reg         expired
);
    reg [31:0] prescale;  // cycles within the current millisecond
    reg [31:0] remaining; // milliseconds still to go

    // load wins; expired stays high until the next load
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            prescale  <= 32'h0;
            remaining <= 32'h0;
            expired   <= 1'b0;
        end
        else if (load)
        begin
            prescale  <= 32'h0;
            remaining <= load_ms;
            expired   <= 1'b0;
        end
        else if (!expired)
        begin
            if (remaining == 32'h0)
                expired <= 1'b1;
            else if (prescale == CYCLES_PER_MS - 1)
            begin
                prescale  <= 32'h0;
                remaining <= remaining - 32'h1;
            end
            else
                prescale <= prescale + 32'h1;
        end
    end
endmodule // ms_tick_counter

// *** rtl/charger_mppt_thermal_jeita_config.v ***
`timescale 1ns/1ps
`include "charger_cfg_regs.vh"
module charger_mppt_thermal_jeita_config #(
    parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    // register access from the serial command front end
    input  wire [7:0]  reg_addr,
    input  wire        reg_write,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // reset sources for the configuration
    input  wire        register_reset_cmd,
    input  wire        watchdog_expired,
    // open-circuit measurement
    input  wire [15:0] open_circuit_mv,
    input  wire        open_circuit_valid,
    output reg         converter_stop,
    output reg         sample_request,
    output reg  [15:0] input_voltage_limit,
    output reg         limit_update,
    // decoded thermal and pulldown controls
    output reg  [1:0]  thermal_regulation_threshold,
    output reg  [1:0]  thermal_shutdown_threshold,
    output reg         bus_rail_pulldown_enable,
    output reg         first_sense_pulldown_enable,
    output reg         second_sense_pulldown_enable,
    // temperature range charge adjustments
    output reg         hot_range_suspend,
    output reg  [9:0]  hot_voltage_reduction_mv,
    output reg  [6:0]  hot_current_percent,
    output reg         cold_range_suspend,
    output reg  [6:0]  cold_current_percent
);
    // one-hot tracking states
    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_SETTLE = 4'h2;
    localparam [3:0] ST_SAMPLE = 4'h4;
    localparam [3:0] ST_WAIT   = 4'h8;

    reg  [7:0]  solar_tracking_control;   // tracking setup
    reg  [7:0]  temperature_control;      // thermal setup
    reg  [7:0]  thermistor_charge_adjust; // hot/cold adjustments
    reg  [3:0]  state;                    // tracking sequencer
    reg  [3:0]  next_state;
    reg         timer_load;               // restart the ms counter
    reg  [31:0] timer_ms;                 // value to load
    wire        timer_done;               // ms counter reached zero
    wire        track_en;
    wire [2:0]  fraction_code;
    reg  [25:0] scaled;                   // voltage times sixteenths

    assign track_en      = solar_tracking_control[`FLD_TRACK_EN];
    assign fraction_code = solar_tracking_control[`FLD_FRACTION_HI:`FLD_FRACTION_LO];

    // settle delay in ms for a 2-bit code
    function [31:0] settle_ms;
        input [1:0] code;
        begin
            case (code)
                2'h0:    settle_ms = `SETTLE_MS_0;
                2'h1:    settle_ms = `SETTLE_MS_1;
                2'h2:    settle_ms = `SETTLE_MS_2;
                default: settle_ms = `SETTLE_MS_3;
            endcase
        end
    endfunction

    // repeat interval in ms for a 2-bit code
    function [31:0] interval_ms;
        input [1:0] code;
        begin
            case (code)
                2'h0:    interval_ms = `INTERVAL_MS_0;
                2'h1:    interval_ms = `INTERVAL_MS_1;
                2'h2:    interval_ms = `INTERVAL_MS_2;
                default: interval_ms = `INTERVAL_MS_3;
            endcase
        end
    endfunction

    // current scale for a 2-bit adjust code: 0 suspends, 3 unchanged
    function [6:0] current_pct;
        input [1:0] code;
        begin
            case (code)
                2'h1:    current_pct = 7'd20;
                2'h2:    current_pct = 7'd40;
                2'h3:    current_pct = 7'd100;
                default: current_pct = 7'd0;
            endcase
        end
    endfunction

    // register writes; register reset restores all, watchdog a subset
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            solar_tracking_control   <= `RST_SOLAR_TRACKING_CONTROL;
            temperature_control      <= `RST_TEMPERATURE_CONTROL;
            thermistor_charge_adjust <= `RST_THERMISTOR_CHARGE_ADJUST;
        end
        else if (register_reset_cmd)
        begin
            solar_tracking_control   <= `RST_SOLAR_TRACKING_CONTROL;
            temperature_control      <= `RST_TEMPERATURE_CONTROL;
            thermistor_charge_adjust <= `RST_THERMISTOR_CHARGE_ADJUST;
        end
        else if (watchdog_expired)
        begin
            // tracking register untouched by the watchdog
            temperature_control <= (temperature_control & ~`WDOG_TEMPERATURE_CONTROL)
                                 | (`RST_TEMPERATURE_CONTROL & `WDOG_TEMPERATURE_CONTROL);
            thermistor_charge_adjust <= `RST_THERMISTOR_CHARGE_ADJUST;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                `OFS_SOLAR_TRACKING_CONTROL:
                    solar_tracking_control <= reg_wdata & `MASK_SOLAR_TRACKING_CONTROL;
                `OFS_TEMPERATURE_CONTROL:
                    temperature_control <= reg_wdata & `MASK_TEMPERATURE_CONTROL;
                `OFS_THERMISTOR_CHARGE_ADJUST:
                    thermistor_charge_adjust <= reg_wdata & `MASK_THERMISTOR_CHARGE_ADJUST;
                default:
                    ; // other offsets belong to neighbouring registers
            endcase
        end
    end

    // read mux; unknown offsets read zero
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                `OFS_SOLAR_TRACKING_CONTROL:   reg_rdata <= solar_tracking_control;
                `OFS_TEMPERATURE_CONTROL:      reg_rdata <= temperature_control;
                `OFS_THERMISTOR_CHARGE_ADJUST: reg_rdata <= thermistor_charge_adjust;
                default:                       reg_rdata <= 8'h00;
            endcase
        end
    end

    // decoded controls, registered
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            thermal_regulation_threshold <= 2'h3;
            thermal_shutdown_threshold   <= 2'h0;
            bus_rail_pulldown_enable     <= 1'b0;
            first_sense_pulldown_enable  <= 1'b0;
            second_sense_pulldown_enable <= 1'b0;
            hot_range_suspend            <= 1'b0;
            hot_voltage_reduction_mv     <= 10'd400;
            hot_current_percent          <= 7'd100;
            cold_range_suspend           <= 1'b0;
            cold_current_percent         <= 7'd20;
        end
        else
        begin
            thermal_regulation_threshold <= temperature_control[7:6];
            thermal_shutdown_threshold   <= temperature_control[5:4];
            bus_rail_pulldown_enable     <= temperature_control[3];
            first_sense_pulldown_enable  <= temperature_control[2];
            second_sense_pulldown_enable <= temperature_control[1];
            hot_current_percent  <= current_pct(thermistor_charge_adjust[4:3]);
            cold_current_percent <= current_pct(thermistor_charge_adjust[2:1]);
            // any zero code suspends charging in that range
            hot_range_suspend  <= (thermistor_charge_adjust[7:5] == 3'h0)
                               || (thermistor_charge_adjust[4:3] == 2'h0);
            cold_range_suspend <= (thermistor_charge_adjust[2:1] == 2'h0);
            case (thermistor_charge_adjust[7:5])
                3'h1:    hot_voltage_reduction_mv <= 10'd800;
                3'h2:    hot_voltage_reduction_mv <= 10'd600;
                3'h3:    hot_voltage_reduction_mv <= 10'd400;
                3'h4:    hot_voltage_reduction_mv <= 10'd400;
                3'h5:    hot_voltage_reduction_mv <= 10'd200;
                3'h6:    hot_voltage_reduction_mv <= 10'd100;
                default: hot_voltage_reduction_mv <= 10'd0;  // unchanged or suspended
            endcase
        end
    end

    // tracking sequencer next state
    always @*
    begin
        next_state = state;
        timer_load = 1'b0;
        timer_ms   = 32'h0;
        case (state)
            ST_IDLE:
                if (track_en)
                begin
                    next_state = ST_SETTLE;
                    timer_load = 1'b1;
                    timer_ms   = settle_ms(solar_tracking_control[`FLD_SETTLE_HI:`FLD_SETTLE_LO]);
                end
            ST_SETTLE:
                if (timer_done)
                    next_state = ST_SAMPLE;
            ST_SAMPLE:
                if (open_circuit_valid)
                begin
                    next_state = ST_WAIT;
                    timer_load = 1'b1;
                    timer_ms   = interval_ms(solar_tracking_control[`FLD_INTERVAL_HI:`FLD_INTERVAL_LO]);
                end
            ST_WAIT:
                if (!track_en)
                    next_state = ST_IDLE;
                else if (timer_done)
                begin
                    next_state = ST_SETTLE;
                    timer_load = 1'b1;
                    timer_ms   = settle_ms(solar_tracking_control[`FLD_SETTLE_HI:`FLD_SETTLE_LO]);
                end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // limit = voltage * (9 + code) / 16; the multiplier needs five bits, since code 7 gives sixteen
    always @*
    begin
        scaled = {10'h0, open_circuit_mv} * {21'h0, 5'h09 + {2'h0, fraction_code}};
    end

    // sequencer registers and outputs
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state               <= ST_IDLE;
            converter_stop      <= 1'b0;
            sample_request      <= 1'b0;
            input_voltage_limit <= 16'h0000;
            limit_update        <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            converter_stop <= (next_state == ST_SETTLE) || (next_state == ST_SAMPLE);
            sample_request <= (next_state == ST_SAMPLE);
            limit_update   <= 1'b0;
            if (state == ST_SAMPLE && open_circuit_valid)
            begin
                input_voltage_limit <= scaled[19:4];
                limit_update        <= 1'b1;
            end
        end
    end

    // millisecond timer for settle and interval
    ms_tick_counter #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .load    (timer_load),
        .load_ms (timer_ms),
        .expired (timer_done)
    );
endmodule // charger_mppt_thermal_jeita_config

// *** testbench/charger_cfg_props.sv ***
`timescale 1ns/1ps
`include "charger_cfg_regs.vh"
// watches the configuration block from its ports only
module charger_cfg_props #(
    parameter CYCLES_PER_MS = 1
) (
    // clock and reset
    input wire        sys_clk,
    input wire        reset,
    // register access
    input wire [7:0]  reg_addr,
    input wire        reg_write,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    // reset sources
    input wire        register_reset_cmd,
    input wire        watchdog_expired,
    // open-circuit measurement
    input wire [15:0] open_circuit_mv,
    input wire        open_circuit_valid,
    input wire        converter_stop,
    input wire        sample_request,
    input wire [15:0] input_voltage_limit,
    input wire        limit_update,
    // decoded controls
    input wire [1:0]  thermal_regulation_threshold,
    input wire [1:0]  thermal_shutdown_threshold,
    input wire        bus_rail_pulldown_enable,
    input wire        first_sense_pulldown_enable,
    input wire        second_sense_pulldown_enable,
    input wire        hot_range_suspend,
    input wire [9:0]  hot_voltage_reduction_mv,
    input wire [6:0]  hot_current_percent,
    input wire        cold_range_suspend,
    input wire [6:0]  cold_current_percent
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // temperature decodes gathered in register bit order
    wire [6:0] temp_fields = {thermal_regulation_threshold, thermal_shutdown_threshold,
                              bus_rail_pulldown_enable, first_sense_pulldown_enable, second_sense_pulldown_enable};

    a_unmapped_reads_zero: assert property (!(reg_addr inside {8'h15, 8'h16, 8'h17}) |=> reg_rdata == 8'h00)
        else $error("unmapped offset read back nonzero");
    a_reserved_bit_zero: assert property ((reg_addr == 8'h16 || reg_addr == 8'h17) |=> !reg_rdata[0])
        else $error("reserved bit read back as one");
    a_write_reaches_decode: assert property (reg_write && reg_addr == `OFS_TEMPERATURE_CONTROL
        && !register_reset_cmd && !watchdog_expired |-> ##2 temp_fields == $past(reg_wdata[7:1], 2))
        else $error("temperature decodes do not follow the written byte");
    a_wdog_restores_fields: assert property (watchdog_expired && !register_reset_cmd |-> ##2
        thermal_shutdown_threshold == 2'h0 && thermal_regulation_threshold == 2'h3 && hot_current_percent == 7'd100
        && cold_current_percent == 7'd20 && hot_voltage_reduction_mv == 10'd400)
        else $error("watchdog expiry did not restore defaults");
    a_reset_cmd_restores: assert property (register_reset_cmd |-> ##2 temp_fields == 7'h60)
        else $error("register reset command did not restore temperature fields");
    a_settle_before_sample: assert property ($rose(converter_stop) |-> !sample_request [*8])
        else $error("sample requested before the settle delay");
    a_stop_covers_sample: assert property (sample_request |-> converter_stop)
        else $error("sampling while the converter switches");
    a_limit_after_valid: assert property (open_circuit_valid && sample_request |=> limit_update && !converter_stop)
        else $error("measurement taken without a limit update");
    a_limit_has_cause: assert property (limit_update |-> $past(open_circuit_valid) && !sample_request)
        else $error("limit update without a measurement");
    a_limit_single_pulse: assert property (limit_update |=> !limit_update)
        else $error("limit update longer than one cycle");
endmodule // charger_cfg_props

bind charger_mppt_thermal_jeita_config charger_cfg_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) charger_cfg_props_inst (
    .sys_clk, .reset, .reg_addr, .reg_write, .reg_wdata, .reg_rdata, .register_reset_cmd, .watchdog_expired,
    .open_circuit_mv, .open_circuit_valid, .converter_stop, .sample_request, .input_voltage_limit, .limit_update,
    .thermal_regulation_threshold, .thermal_shutdown_threshold, .bus_rail_pulldown_enable,
    .first_sense_pulldown_enable, .second_sense_pulldown_enable, .hot_range_suspend, .hot_voltage_reduction_mv,
    .hot_current_percent, .cold_range_suspend, .cold_current_percent);

// *** testbench/open_circuit_meter.sv ***
`timescale 1ns/1ps
// stands in for the measurement path that reads the open bus rail
module open_circuit_meter (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    // request from the block, panel voltage and conversion time
    input  wire        sample_request,
    input  wire [15:0] panel_mv,
    input  wire [3:0]  conv_cycles,
    // result
    output reg  [15:0] open_circuit_mv,
    output reg         open_circuit_valid
);
    reg [3:0] wait_cnt;  // cycles spent converting
    // answer after conv_cycles; outside the strobe the data bus shows junk, not the last result
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wait_cnt <= 4'h0;
            open_circuit_valid <= 1'b0;
            open_circuit_mv <= 16'hFFFF;
        end
        else if (sample_request && !open_circuit_valid && wait_cnt == conv_cycles)
        begin
            open_circuit_valid <= 1'b1;
            open_circuit_mv <= panel_mv;
        end
        else
        begin
            // count only while a request stands
            wait_cnt <= (sample_request && !open_circuit_valid) ? wait_cnt + 4'h1 : 4'h0;
            open_circuit_valid <= 1'b0;
            open_circuit_mv <= ~panel_mv;
        end
    end
endmodule // open_circuit_meter

// *** testbench/charger_mppt_thermal_jeita_config_test.sv ***
`timescale 1ns/1ps
`include "charger_cfg_regs.vh"
`define CHECK(got, exp) \
    begin \
        n_tests = n_tests + 1; \
        if ((got) !== (exp)) \
        begin \
            num_errors = num_errors + 1; \
            $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module charger_mppt_thermal_jeita_config_test;
    // one tick per millisecond keeps the long delays short
    localparam CPM = 1;
    // hot voltage reductions by code, code 0 lowest
    localparam [79:0] RED = {10'd0, 10'd100, 10'd200, 10'd400, 10'd400, 10'd600, 10'd800, 10'd0};
    // current percentages by code, code 0 is a suspend
    localparam [27:0] PCT = {7'd100, 7'd40, 7'd20, 7'd0};
    reg         sys_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, register_reset_cmd = 1'b0, watchdog_expired = 1'b0;
    reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rv;
    reg  [15:0] panel_mv = 16'h2710;
    reg  [3:0]  conv_cycles = 4'h1;
    wire [15:0] open_circuit_mv, input_voltage_limit;
    wire [7:0]  reg_rdata;
    wire [9:0]  hot_voltage_reduction_mv;
    wire [6:0]  hot_current_percent, cold_current_percent;
    wire [1:0]  thermal_regulation_threshold, thermal_shutdown_threshold;
    wire        open_circuit_valid, converter_stop, sample_request, limit_update, hot_range_suspend;
    wire        bus_rail_pulldown_enable, first_sense_pulldown_enable, second_sense_pulldown_enable, cold_range_suspend;
    wire [6:0]  temp_dec = {thermal_regulation_threshold, thermal_shutdown_threshold,
                            bus_rail_pulldown_enable, first_sense_pulldown_enable, second_sense_pulldown_enable};
    integer     num_errors = 0, n_tests = 0, i, n, k, m;

    charger_mppt_thermal_jeita_config #(.CYCLES_PER_MS(CPM)) charger_mppt_thermal_jeita_config_inst (
        .sys_clk, .reset, .reg_addr, .reg_write, .reg_wdata, .reg_rdata, .register_reset_cmd, .watchdog_expired,
        .open_circuit_mv, .open_circuit_valid, .converter_stop, .sample_request, .input_voltage_limit, .limit_update,
        .thermal_regulation_threshold, .thermal_shutdown_threshold, .bus_rail_pulldown_enable,
        .first_sense_pulldown_enable, .second_sense_pulldown_enable, .hot_range_suspend, .hot_voltage_reduction_mv,
        .hot_current_percent, .cold_range_suspend, .cold_current_percent);
    open_circuit_meter open_circuit_meter_inst (.sys_clk, .reset, .sample_request, .panel_mv, .conv_cycles,
        .open_circuit_mv, .open_circuit_valid);

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // one-cycle write strobe, driven off the sampling edge
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge sys_clk);
            reg_addr = a;
            reg_wdata = d;
            reg_write = 1'b1;
            @(negedge sys_clk);
            reg_write = 1'b0;
        end
    endtask
    // read data is registered, so look one cycle after the address
    task chk(input [7:0] a, input [7:0] e);
        begin
            @(negedge sys_clk);
            reg_addr = a;
            @(negedge sys_clk);
            `CHECK(reg_rdata, e)
        end
    endtask
    // pulse one of the two reset sources for one cycle: register reset when sel is 1, watchdog when 0
    task pulse(input sel);
        begin
            @(negedge sys_clk);
            register_reset_cmd = sel;
            watchdog_expired = ~sel;
            @(negedge sys_clk);
            register_reset_cmd = 1'b0;
            watchdog_expired = 1'b0;
        end
    endtask
    // bounded wait for stop (0), sample request (1) or limit update (2)
    task wait_hi(input integer which, input integer limit, output integer c);
        begin
            c = 0;
            while ((which == 0 ? converter_stop : which == 1 ? sample_request : limit_update) !== 1'b1 && c < limit)
            begin
                @(negedge sys_clk);
                c = c + 1;
            end
            `CHECK(c < limit, 1'b1)
        end
    endtask
    // verdict and end of run
    task results;
        begin
            if (num_errors == 0 && n_tests > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // a hang past half as long again as the expected run counts as a failure
    initial
    begin
        #(25.0 * 90000);
        num_errors = num_errors + 1;
        results;
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        chk(`OFS_SOLAR_TRACKING_CONTROL, 8'hAA);
        chk(`OFS_TEMPERATURE_CONTROL, 8'hC0);
        chk(`OFS_THERMISTOR_CHARGE_ADJUST, 8'h7A);
        chk(8'h14, 8'h00);
        `CHECK(temp_dec, 7'h60)
        `CHECK({hot_range_suspend, cold_range_suspend, hot_voltage_reduction_mv}, 12'h190)
        `CHECK({hot_current_percent, cold_current_percent}, {7'd100, 7'd20})
        // all ones, then a mixed pattern, into the temperature register
        wr(`OFS_TEMPERATURE_CONTROL, 8'hFF);
        chk(`OFS_TEMPERATURE_CONTROL, 8'hFE);
        `CHECK(temp_dec, 7'h7F)
        wr(`OFS_TEMPERATURE_CONTROL, 8'h5A);
        chk(`OFS_TEMPERATURE_CONTROL, 8'h5A);
        `CHECK(temp_dec, 7'h2D)
        // every code of the three adjustment fields
        for (i = 0; i < 8; i = i + 1)
        begin
            rv = {i[2:0], i[1:0], i[1:0], 1'b1};
            wr(`OFS_THERMISTOR_CHARGE_ADJUST, rv);
            chk(`OFS_THERMISTOR_CHARGE_ADJUST, rv & 8'hFE);
            `CHECK(hot_voltage_reduction_mv, RED[i*10 +: 10])
            `CHECK(hot_range_suspend, i == 0 || i[1:0] == 0)
            `CHECK(cold_range_suspend, i[1:0] == 0)
            `CHECK(hot_current_percent, PCT[i[1:0]*7 +: 7])
            `CHECK(cold_current_percent, PCT[i[1:0]*7 +: 7])
        end
        // a write to a neighbouring offset lands nowhere
        wr(8'h18, 8'hFF);
        chk(8'h18, 8'h00);
        wr(`OFS_SOLAR_TRACKING_CONTROL, 8'h54);
        pulse(1'b0);
        chk(`OFS_SOLAR_TRACKING_CONTROL, 8'h54);
        chk(`OFS_TEMPERATURE_CONTROL, 8'hCA);
        chk(`OFS_THERMISTOR_CHARGE_ADJUST, 8'h7A);
        pulse(1'b1);
        chk(`OFS_SOLAR_TRACKING_CONTROL, 8'hAA);
        chk(`OFS_TEMPERATURE_CONTROL, 8'hC0);
        // tracking: lowest fraction, shortest settle and interval, prompt meter
        `CHECK(converter_stop, 1'b0)
        wr(`OFS_SOLAR_TRACKING_CONTROL, 8'h01);
        wait_hi(0, 10, n);
        wait_hi(1, 200, n);
        `CHECK(n >= 49 && n <= 53, 1'b1)
        wait_hi(2, 40, k);
        `CHECK(input_voltage_limit, 16'd5625)
        // full fraction next time, slow meter
        wr(`OFS_SOLAR_TRACKING_CONTROL, 8'hE1);
        panel_mv = 16'h3039;
        conv_cycles = 4'hC;
        wait_hi(0, 31000, m);
        `CHECK(n + k + m + 2 >= 29990 && n + k + m + 2 <= 30080, 1'b1)
        wait_hi(2, 700, k);
        `CHECK(input_voltage_limit, 16'h3039)
        // once disabled, no further cycle may start
        wr(`OFS_SOLAR_TRACKING_CONTROL, 8'hE0);
        k = 0;
        repeat (31000)
        begin
            @(negedge sys_clk);
            k = k + (converter_stop === 1'b1);
        end
        `CHECK(k, 0)
        results;
    end
endmodule // charger_mppt_thermal_jeita_config_test
